// *** common/ddr2_cmd_pkg.sv ***
// Shared constants and types for the command decoder and its bench.
// Assumes a 200 MHz REF_CLK to which the command pins are synchronous.
package ddr2_cmd_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int ROW_W = 13;
  localparam int COL_W = 10;
  localparam int BANK_W = 2;
  localparam int NUM_BANKS = 4;
  localparam int NUM_MR = 4;
  localparam int AP_BIT = 10;
  localparam int BEAT_W = 4;

  // ----------------------------------------------------------------
  // Command encodings as {RAS_N, CAS_N, WE_N}
  // ----------------------------------------------------------------
  localparam logic [2:0] CMD_MRS = 3'h0;
  localparam logic [2:0] CMD_REF = 3'h1;
  localparam logic [2:0] CMD_PRE = 3'h2;
  localparam logic [2:0] CMD_ACT = 3'h3;
  localparam logic [2:0] CMD_WR = 3'h4;
  localparam logic [2:0] CMD_RD = 3'h5;
  localparam logic [2:0] CMD_NOP = 3'h7;

  // ----------------------------------------------------------------
  // Mode register fields
  // ----------------------------------------------------------------
  localparam int MR_BASE = 0;
  localparam int MR_EXT1 = 1;
  localparam int BL_LSB = 0;
  localparam int BL_MSB = 2;
  localparam logic [2:0] BL_CODE8 = 3'h3;
  localparam logic [BEAT_W-1:0] BEATS_BL4 = 4'h4;
  localparam logic [BEAT_W-1:0] BEATS_BL8 = 4'h8;
  localparam int AL_LSB = 3;
  localparam int AL_MSB = 5;
  localparam int AL_W = 3;
  localparam logic [AL_W-1:0] AL_MAX = 3'h5;
  localparam int RTT_LO_BIT = 2;
  localparam int RTT_HI_BIT = 6;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 5;
  localparam int TRP_NS = 15;
  localparam int PRE_CNT_W = 3;
  localparam logic [PRE_CNT_W-1:0] TRP_CYC = PRE_CNT_W'((TRP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int ODT_SYNC_LEN = 3;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    BANK_IDLE = 2'h0,
    BANK_ACTIVE = 2'h1,
    BANK_PRECHARGING = 2'h2
  } bank_state_t;

  typedef enum logic [1:0] {
    PWR_ACTIVE = 2'h0,
    PWR_DOWN = 2'h1,
    PWR_SELF_REFRESH = 2'h2
  } pwr_state_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic ap;
    logic [BANK_W-1:0] bank;
    logic [COL_W-1:0] col;
  } col_cmd_t;

endpackage

// *** common/stream_if.sv ***
// Valid/ready stream carrying one word from a producer into a buffer and out again.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps
interface stream_if #(parameter int WIDTH = 9);
  logic push_valid;
  logic push_ready;
  logic [WIDTH-1:0] push_data;
  logic pop_valid;
  logic pop_ready;
  logic [WIDTH-1:0] pop_data;

  modport buffer (input push_valid, input push_data, input pop_ready,
                  output push_ready, output pop_valid, output pop_data);
  modport user (output push_valid, output push_data, output pop_ready,
                input push_ready, input pop_valid, input pop_data);
endinterface

// *** logic/stream_fifo.sv ***
// Flip-flop FIFO with valid and ready on both sides.
// Assumes DEPTH is a power of two and one clock for both sides.
`timescale 1ns/10ps
module stream_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 32
) (
  input wire logic clk,
  input wire logic rst,
  stream_if.buffer port
);
  localparam int PTR_W = $clog2(DEPTH);
  localparam int CNT_W = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PTR_W-1:0] wr_ptr;
    logic [PTR_W-1:0] rd_ptr;
    logic [CNT_W-1:0] count;
  } fifo_state_t;

  fifo_state_t state_reg;
  fifo_state_t state_next;
  logic push;
  logic pop;

  assign port.push_ready = state_reg.count != CNT_W'(DEPTH);
  assign port.pop_valid = state_reg.count != '0;
  assign port.pop_data = state_reg.mem[state_reg.rd_ptr];
  assign push = port.push_valid && port.push_ready;
  assign pop = port.pop_ready && port.pop_valid;

  always_comb begin
    state_next = state_reg;
    if (push) begin
      state_next.mem[state_reg.wr_ptr] = port.push_data;
      state_next.wr_ptr = state_reg.wr_ptr + 1'b1;
    end
    if (pop) begin
      state_next.rd_ptr = state_reg.rd_ptr + 1'b1;
    end
    if (push && !pop) begin
      state_next.count = state_reg.count + 1'b1;
    end else if (pop && !push) begin
      state_next.count = state_reg.count - 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end
endmodule

// *** logic/ddr2_cmd_decoder.sv ***
// Command decoder of a four-bank DDR2 memory, with write-data buffer and array write port.
// Assumes the command pins, CKE and write data are synchronous to REF_CLK; ODT is not.
`timescale 1ns/10ps
module ddr2_cmd_decoder #(
  parameter int DQ_W = 8,
  parameter int FIFO_DEPTH = 32,
  parameter bit X16 = 1'b0
) (
  input wire logic REF_CLK,
  input wire logic RESET,
  input wire logic CKE,
  input wire logic CS_N,
  input wire logic RAS_N,
  input wire logic CAS_N,
  input wire logic WE_N,
  input wire logic [ddr2_cmd_pkg::BANK_W-1:0] BA,
  input wire logic [ddr2_cmd_pkg::ROW_W-1:0] ADDR,
  input wire logic ODT,
  input wire logic WDATA_VALID,
  input wire logic [DQ_W-1:0] WDATA,
  input wire logic [DQ_W/8-1:0] WDM,
  output logic WDATA_READY,
  input wire logic ARRAY_READY,
  output logic ARRAY_WR_EN,
  output logic [ddr2_cmd_pkg::BANK_W-1:0] ARRAY_WR_BANK,
  output logic [ddr2_cmd_pkg::ROW_W-1:0] ARRAY_WR_ROW,
  output logic [ddr2_cmd_pkg::COL_W-1:0] ARRAY_WR_COL,
  output logic [DQ_W-1:0] ARRAY_WR_DATA,
  output logic [DQ_W/8-1:0] ARRAY_WR_BYTE_EN,
  output logic RD_START,
  output logic [ddr2_cmd_pkg::BANK_W-1:0] RD_BANK,
  output logic [ddr2_cmd_pkg::ROW_W-1:0] RD_ROW,
  output logic [ddr2_cmd_pkg::COL_W-1:0] RD_COL,
  output logic REFRESH_PULSE,
  output logic [ddr2_cmd_pkg::ROW_W-1:0] REFRESH_ROW,
  output logic [ddr2_cmd_pkg::NUM_BANKS-1:0] BANK_OPEN,
  output logic [ddr2_cmd_pkg::NUM_MR*ddr2_cmd_pkg::ROW_W-1:0] MODE_REGS,
  output logic SELF_REFRESH,
  output logic POWER_DOWN,
  output logic DLL_ENABLED,
  output logic TERM_ON
);
  localparam int DM_W = DQ_W / 8;
  localparam int WORD_W = DQ_W + DM_W;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic cke_prev;
    logic [ddr2_cmd_pkg::ODT_SYNC_LEN-1:0] odt_s;
    logic odt_level;
    ddr2_cmd_pkg::pwr_state_t pwr;
    logic dll_off;
    logic term_on;
    ddr2_cmd_pkg::bank_state_t [ddr2_cmd_pkg::NUM_BANKS-1:0] bank;
    logic [ddr2_cmd_pkg::NUM_BANKS-1:0][ddr2_cmd_pkg::PRE_CNT_W-1:0] pre_cnt;
    logic [ddr2_cmd_pkg::NUM_BANKS-1:0][ddr2_cmd_pkg::ROW_W-1:0] row;
    logic [ddr2_cmd_pkg::NUM_MR-1:0][ddr2_cmd_pkg::ROW_W-1:0] mr;
    ddr2_cmd_pkg::col_cmd_t [ddr2_cmd_pkg::AL_MAX-1:0] pipe;
    logic [ddr2_cmd_pkg::BEAT_W-1:0] wr_left;
    logic [ddr2_cmd_pkg::BANK_W-1:0] wr_bank;
    logic [ddr2_cmd_pkg::ROW_W-1:0] wr_row;
    logic [ddr2_cmd_pkg::COL_W-1:0] wr_col;
    logic wr_ap;
    logic [ddr2_cmd_pkg::BEAT_W-1:0] ap_cnt;
    logic [ddr2_cmd_pkg::BANK_W-1:0] ap_bank;
    logic [ddr2_cmd_pkg::ROW_W-1:0] ref_cnt;
    logic rd_start;
    logic [ddr2_cmd_pkg::BANK_W-1:0] rd_bank;
    logic [ddr2_cmd_pkg::ROW_W-1:0] rd_row;
    logic [ddr2_cmd_pkg::COL_W-1:0] rd_col;
    logic ref_pulse;
    logic [ddr2_cmd_pkg::ROW_W-1:0] ref_row;
    logic arr_en;
    logic [ddr2_cmd_pkg::BANK_W-1:0] arr_bank;
    logic [ddr2_cmd_pkg::ROW_W-1:0] arr_row;
    logic [ddr2_cmd_pkg::COL_W-1:0] arr_col;
    logic [DQ_W-1:0] arr_data;
    logic [DM_W-1:0] arr_be;
  } state_t;

  state_t state_reg;
  state_t state_next;
  logic [2:0] cmd;
  logic cmd_live;
  logic [ddr2_cmd_pkg::AL_W-1:0] al_cur;
  logic drain;
  logic [DM_W-1:0] pop_dm;
  logic [DQ_W-1:0] pop_dq;

  stream_if #(.WIDTH(WORD_W)) wq ();

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [ddr2_cmd_pkg::COL_W-1:0] col_of(input logic [ddr2_cmd_pkg::ROW_W-1:0] a);
    logic [ddr2_cmd_pkg::COL_W-1:0] c;
    c = a[ddr2_cmd_pkg::COL_W-1:0];
    if (X16) begin
      c[ddr2_cmd_pkg::COL_W-1] = 1'b0;
    end
    return c;
  endfunction

  function automatic logic [ddr2_cmd_pkg::BEAT_W-1:0] beats_of(input logic [ddr2_cmd_pkg::ROW_W-1:0] m);
    if (m[ddr2_cmd_pkg::BL_MSB:ddr2_cmd_pkg::BL_LSB] == ddr2_cmd_pkg::BL_CODE8) begin
      return ddr2_cmd_pkg::BEATS_BL8;
    end
    return ddr2_cmd_pkg::BEATS_BL4;
  endfunction

  // ----------------------------------------------------------------
  // Write data buffer
  // ----------------------------------------------------------------
  // Back-pressure: beats only leave the buffer while a write burst is due and the array accepts.
  assign wq.push_valid = WDATA_VALID;
  assign wq.push_data = {WDM, WDATA};
  assign WDATA_READY = wq.push_ready;
  assign drain = (state_reg.wr_left != '0) && ARRAY_READY;
  assign wq.pop_ready = drain;
  assign pop_dm = wq.pop_data[WORD_W-1:DQ_W];
  assign pop_dq = wq.pop_data[DQ_W-1:0];

  stream_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) wbuf (
    .clk(REF_CLK),
    .rst(RESET),
    .port(wq.buffer)
  );

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  assign cmd = {RAS_N, CAS_N, WE_N};
  assign cmd_live = state_reg.cke_prev && CKE && !CS_N;
  // Reserved latency codes are clamped so the pipeline index never runs past its end.
  assign al_cur = (state_reg.mr[ddr2_cmd_pkg::MR_EXT1][ddr2_cmd_pkg::AL_MSB:ddr2_cmd_pkg::AL_LSB]
                   > ddr2_cmd_pkg::AL_MAX) ? ddr2_cmd_pkg::AL_MAX
                  : state_reg.mr[ddr2_cmd_pkg::MR_EXT1][ddr2_cmd_pkg::AL_MSB:ddr2_cmd_pkg::AL_LSB];

  always_comb begin
    ddr2_cmd_pkg::col_cmd_t inc;
    ddr2_cmd_pkg::col_cmd_t ex;
    logic [ddr2_cmd_pkg::NUM_BANKS-1:0] pre_req;
    state_next = state_reg;
    inc = '0;
    ex = '0;
    pre_req = '0;
    state_next.rd_start = 1'b0;
    state_next.ref_pulse = 1'b0;
    state_next.arr_en = 1'b0;
    state_next.cke_prev = CKE;

    // Termination pin: a change counts once the second and third stages agree.
    state_next.odt_s = {state_reg.odt_s[ddr2_cmd_pkg::ODT_SYNC_LEN-2:0], ODT};
    if (state_reg.odt_s[1] == state_reg.odt_s[2]) begin
      state_next.odt_level = state_reg.odt_s[2];
    end

    // Precharge timers keep running whatever the command pins show.
    for (int b = 0; b < ddr2_cmd_pkg::NUM_BANKS; b++) begin
      if (state_reg.bank[b] == ddr2_cmd_pkg::BANK_PRECHARGING) begin
        if (state_reg.pre_cnt[b] <= 3'h1) begin
          state_next.bank[b] = ddr2_cmd_pkg::BANK_IDLE;
          state_next.pre_cnt[b] = '0;
        end else begin
          state_next.pre_cnt[b] = state_reg.pre_cnt[b] - 1'b1;
        end
      end
    end

    // Power state from clock enable edges.
    if (state_reg.cke_prev && !CKE) begin
      if (!CS_N && cmd == ddr2_cmd_pkg::CMD_REF) begin
        state_next.pwr = ddr2_cmd_pkg::PWR_SELF_REFRESH;
        state_next.dll_off = 1'b1;
      end else begin
        state_next.pwr = ddr2_cmd_pkg::PWR_DOWN;
      end
    end else if (!state_reg.cke_prev && CKE) begin
      state_next.pwr = ddr2_cmd_pkg::PWR_ACTIVE;
      state_next.dll_off = 1'b0;
    end

    if (cmd_live) begin
      unique case (cmd)
        ddr2_cmd_pkg::CMD_MRS: begin
          state_next.mr[BA] = ADDR;
        end
        ddr2_cmd_pkg::CMD_ACT: begin
          state_next.bank[BA] = ddr2_cmd_pkg::BANK_ACTIVE;
          state_next.row[BA] = ADDR;
        end
        ddr2_cmd_pkg::CMD_PRE: begin
          if (ADDR[ddr2_cmd_pkg::AP_BIT]) begin
            pre_req = '1;
          end else begin
            pre_req[BA] = 1'b1;
          end
        end
        ddr2_cmd_pkg::CMD_RD, ddr2_cmd_pkg::CMD_WR: begin
          inc.valid = 1'b1;
          inc.write = (cmd == ddr2_cmd_pkg::CMD_WR);
          inc.ap = ADDR[ddr2_cmd_pkg::AP_BIT];
          inc.bank = BA;
          inc.col = col_of(ADDR);
        end
        ddr2_cmd_pkg::CMD_REF: begin
          state_next.ref_pulse = 1'b1;
          state_next.ref_row = state_reg.ref_cnt;
          state_next.ref_cnt = state_reg.ref_cnt + 1'b1;
        end
        ddr2_cmd_pkg::CMD_NOP: begin
          state_next.ref_pulse = 1'b0;
        end
        default: begin
          state_next.ref_pulse = 1'b0;
        end
      endcase
    end

    // Additive latency pipeline: slot 0 reaches the core this cycle.
    for (int i = 0; i < ddr2_cmd_pkg::AL_MAX - 1; i++) begin
      state_next.pipe[i] = state_reg.pipe[i+1];
    end
    state_next.pipe[ddr2_cmd_pkg::AL_MAX-1] = '0;
    if (al_cur == '0) begin
      ex = inc;
    end else begin
      ex = state_reg.pipe[0];
      if (inc.valid) begin
        state_next.pipe[al_cur - 1'b1] = inc;
      end
    end

    if (ex.valid && ex.write) begin
      state_next.wr_left = beats_of(state_reg.mr[ddr2_cmd_pkg::MR_BASE]);
      state_next.wr_bank = ex.bank;
      state_next.wr_row = state_reg.row[ex.bank];
      state_next.wr_col = ex.col;
      state_next.wr_ap = ex.ap;
    end else if (ex.valid) begin
      state_next.rd_start = 1'b1;
      state_next.rd_bank = ex.bank;
      state_next.rd_row = state_reg.row[ex.bank];
      state_next.rd_col = ex.col;
      if (ex.ap) begin
        state_next.ap_cnt = beats_of(state_reg.mr[ddr2_cmd_pkg::MR_BASE]) >> 1;
        state_next.ap_bank = ex.bank;
      end
    end

    // Read auto precharge fires when the burst's clock count runs out.
    if (state_reg.ap_cnt != '0) begin
      state_next.ap_cnt = state_reg.ap_cnt - 1'b1;
      if (state_reg.ap_cnt == 4'h1) begin
        pre_req[state_reg.ap_bank] = 1'b1;
      end
    end

    if (drain) begin
      state_next.arr_en = 1'b1;
      state_next.arr_bank = state_reg.wr_bank;
      state_next.arr_row = state_reg.wr_row;
      state_next.arr_col = state_reg.wr_col;
      state_next.arr_data = pop_dq;
      state_next.arr_be = ~pop_dm;
      state_next.wr_col = state_reg.wr_col + 1'b1;
      state_next.wr_left = state_reg.wr_left - 1'b1;
      if (state_reg.wr_left == 4'h1 && state_reg.wr_ap) begin
        pre_req[state_reg.wr_bank] = 1'b1;
      end
    end

    // An idle bank takes the precharge and stays idle; a precharging one restarts its count unless that count runs out this cycle.
    for (int b = 0; b < ddr2_cmd_pkg::NUM_BANKS; b++) begin
      if (pre_req[b] && state_next.bank[b] != ddr2_cmd_pkg::BANK_IDLE) begin
        state_next.bank[b] = ddr2_cmd_pkg::BANK_PRECHARGING;
        state_next.pre_cnt[b] = ddr2_cmd_pkg::TRP_CYC;
      end
    end

    state_next.term_on = state_next.odt_level
      && (state_next.mr[ddr2_cmd_pkg::MR_EXT1][ddr2_cmd_pkg::RTT_LO_BIT]
          || state_next.mr[ddr2_cmd_pkg::MR_EXT1][ddr2_cmd_pkg::RTT_HI_BIT])
      && state_next.pwr != ddr2_cmd_pkg::PWR_SELF_REFRESH;
  end

  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign ARRAY_WR_EN = state_reg.arr_en;
  assign ARRAY_WR_BANK = state_reg.arr_bank;
  assign ARRAY_WR_ROW = state_reg.arr_row;
  assign ARRAY_WR_COL = state_reg.arr_col;
  assign ARRAY_WR_DATA = state_reg.arr_data;
  assign ARRAY_WR_BYTE_EN = state_reg.arr_be;
  assign RD_START = state_reg.rd_start;
  assign RD_BANK = state_reg.rd_bank;
  assign RD_ROW = state_reg.rd_row;
  assign RD_COL = state_reg.rd_col;
  assign REFRESH_PULSE = state_reg.ref_pulse;
  assign REFRESH_ROW = state_reg.ref_row;
  assign MODE_REGS = state_reg.mr;
  assign SELF_REFRESH = state_reg.pwr == ddr2_cmd_pkg::PWR_SELF_REFRESH;
  assign POWER_DOWN = state_reg.pwr == ddr2_cmd_pkg::PWR_DOWN;
  assign DLL_ENABLED = !state_reg.dll_off;
  assign TERM_ON = state_reg.term_on;

  for (genvar g = 0; g < ddr2_cmd_pkg::NUM_BANKS; g++) begin : g_open
    assign BANK_OPEN[g] = state_reg.bank[g] == ddr2_cmd_pkg::BANK_ACTIVE;
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (RESET);

  // Each step looks back to the bank address of the precharge itself, not the address of that cycle.
  sequence prech_window;
    state_reg.bank[$past(BA)] == ddr2_cmd_pkg::BANK_PRECHARGING
    ##1 state_reg.bank[$past(BA, 2)] == ddr2_cmd_pkg::BANK_PRECHARGING
    ##1 state_reg.bank[$past(BA, 3)] == ddr2_cmd_pkg::BANK_PRECHARGING;
  endsequence

  sequence read_out_late;
    !state_reg.rd_start ##1 !state_reg.rd_start ##1 state_reg.rd_start;
  endsequence

  deselect_hold_a: assert property (CS_N |=> $stable(state_reg.mr) && $stable(state_reg.row))
    else $error("Deselect changed a mode register or row.");
  nop_hold_a: assert property (cmd_live && cmd == ddr2_cmd_pkg::CMD_NOP |=> $stable(state_reg.mr))
    else $error("NOP changed a mode register.");
  mode_load_a: assert property (cmd_live && cmd == ddr2_cmd_pkg::CMD_MRS
    |=> state_reg.mr[$past(BA)] == $past(ADDR))
    else $error("Mode register not loaded from address.");
  row_open_a: assert property (cmd_live && cmd == ddr2_cmd_pkg::CMD_ACT
    |=> BANK_OPEN[$past(BA)] && state_reg.row[$past(BA)] == $past(ADDR))
    else $error("Activate did not open the row.");
  read_start_a: assert property (cmd_live && cmd == ddr2_cmd_pkg::CMD_RD && al_cur == 3'h0
    |=> RD_START && RD_COL == col_of($past(ADDR)) && RD_BANK == $past(BA))
    else $error("Read burst did not start at the given column.");
  add_latency_a: assert property (cmd_live && cmd == ddr2_cmd_pkg::CMD_RD && al_cur == 3'h2
    && state_reg.pipe == '0 |=> read_out_late)
    else $error("Read not delayed by the additive latency.");
  write_mask_a: assert property (drain |=> ARRAY_WR_EN && ARRAY_WR_BYTE_EN == ~$past(pop_dm))
    else $error("Write byte enable does not follow the mask.");
  prech_time_a: assert property (cmd_live && cmd == ddr2_cmd_pkg::CMD_PRE && !ADDR[ddr2_cmd_pkg::AP_BIT]
    && BANK_OPEN[BA] && state_reg.ap_cnt == '0 && state_reg.wr_left == '0
    |=> prech_window ##1 state_reg.bank[$past(BA, 4)] == ddr2_cmd_pkg::BANK_IDLE)
    else $error("Precharge period is not three cycles.");
  prech_restart_a: assert property (cmd_live && cmd == ddr2_cmd_pkg::CMD_PRE
    && !ADDR[ddr2_cmd_pkg::AP_BIT] && state_reg.bank[BA] == ddr2_cmd_pkg::BANK_PRECHARGING
    |=> state_reg.pre_cnt[$past(BA)] == ddr2_cmd_pkg::TRP_CYC)
    else $error("Repeated precharge did not restart the period.");
  refresh_row_a: assert property (cmd_live && cmd == ddr2_cmd_pkg::CMD_REF
    |=> REFRESH_PULSE && REFRESH_ROW == $past(state_reg.ref_cnt))
    else $error("Refresh row not taken from the counter.");
  self_ref_a: assert property (state_reg.cke_prev && !CKE && !CS_N && cmd == ddr2_cmd_pkg::CMD_REF
    |=> SELF_REFRESH && !DLL_ENABLED)
    else $error("Self refresh entry did not stop the loop.");
  no_term_sr_a: assert property (SELF_REFRESH |-> !TERM_ON)
    else $error("Termination on during self refresh.");
endmodule

// *** sim/ddr2_ctrl_model.sv ***
// Controller model: drives command pins and write data just after the falling edge.
// Assumes one REF_CLK and a bench that calls its tasks in order.
`timescale 1ns/10ps
module ddr2_ctrl_model (
  input wire logic clk,
  input wire logic rdy,
  output logic cke,
  output logic [3:0] cmd,
  output logic [1:0] ba,
  output logic [12:0] addr,
  output logic wv,
  output logic [8:0] wd
);
  initial begin
    cke = 1'b1;
    cmd = 4'h7;
    ba = 2'h0;
    addr = 13'h0;
    wv = 1'b0;
    wd = 9'h0;
  end
  task automatic issue(input logic cs, input logic [2:0] c, input logic [1:0] b, input logic [12:0] a, input logic k);
    @(negedge clk);
    cke = k;
    cmd = {cs, c};
    ba = b;
    addr = a;
    @(negedge clk);
    cmd = 4'h7;
    // Inverted so a stale address can never pass for a held one.
    ba = ~b;
    addr = ~a;
  endtask
  task automatic push(input logic [8:0] d, input logic last);
    @(negedge clk);
    wv = 1'b1;
    wd = d;
    do @(posedge clk); while (rdy !== 1'b1);
    if (last) begin
      @(negedge clk);
      wv = 1'b0;
      wd = ~d;
    end
  endtask
endmodule

// *** sim/ddr2_cmd_decoder_bench.sv ***
// Bench for the command decoder; the controller model makes every command.
// Assumes the package, stream interface and FIFO are compiled first.
`timescale 1ns/10ps
module ddr2_cmd_decoder_bench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic odt = 1'b1;
  logic cke, wv, rdy, we, rs, rp, sr, dll, tm;
  logic [3:0] cmd, bo;
  logic [1:0] ba;
  logic [12:0] ad, rrow, fr;
  logic [9:0] wcol, rcol;
  logic [8:0] wd;
  logic [7:0] wdat;
  logic [0:0] ben;
  logic [51:0] mr;
  int fail_count = 0;
  int checks = 0;
  always #2.5 clk = ~clk;
  ddr2_ctrl_model ddr2_ctrl_model_i (.clk(clk), .rdy(rdy), .cke(cke), .cmd(cmd), .ba(ba), .addr(ad), .wv(wv), .wd(wd));
  ddr2_cmd_decoder ddr2_cmd_decoder_i (.REF_CLK(clk), .RESET(rst), .CKE(cke), .CS_N(cmd[3]), .RAS_N(cmd[2]),
    .CAS_N(cmd[1]), .WE_N(cmd[0]), .BA(ba), .ADDR(ad), .ODT(odt), .WDATA_VALID(wv), .WDATA(wd[7:0]),
    .WDM(wd[8]), .WDATA_READY(rdy), .ARRAY_READY(1'b1), .ARRAY_WR_EN(we), .ARRAY_WR_BANK(), .ARRAY_WR_ROW(),
    .ARRAY_WR_COL(wcol), .ARRAY_WR_DATA(wdat), .ARRAY_WR_BYTE_EN(ben), .RD_START(rs), .RD_BANK(), .RD_ROW(rrow),
    .RD_COL(rcol), .REFRESH_PULSE(rp), .REFRESH_ROW(fr), .BANK_OPEN(bo), .MODE_REGS(mr), .SELF_REFRESH(sr),
    .POWER_DOWN(), .DLL_ENABLED(dll), .TERM_ON(tm));
  task automatic chk(input string n, input logic [12:0] s, input logic [12:0] e);
    checks++;
    if (s !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    #20000;
    fail_count++;
    print_verdict();
  end
  initial begin
    int n;
    repeat (5) @(negedge clk);
    rst = 1'b0;
    repeat (2) @(negedge clk);
    ddr2_ctrl_model_i.issue(1'b0, ddr2_cmd_pkg::CMD_MRS, 2'h1, 13'h004, 1'b1);
    chk("emr", mr[25:13], 13'h004);
    repeat (6) @(negedge clk);
    chk("term", tm, 13'h1);
    ddr2_ctrl_model_i.issue(1'b1, ddr2_cmd_pkg::CMD_ACT, 2'h2, 13'h7, 1'b1);
    chk("desel", bo, 13'h0);
    ddr2_ctrl_model_i.issue(1'b0, ddr2_cmd_pkg::CMD_ACT, 2'h1, 13'h123, 1'b1);
    chk("open", bo, 13'h2);
    ddr2_ctrl_model_i.issue(1'b0, ddr2_cmd_pkg::CMD_RD, 2'h1, 13'h02a, 1'b1);
    chk("rdgo", rs, 13'h1);
    chk("rdrow", rrow, 13'h123);
    chk("rdcol", rcol, 13'h02a);
    for (int i = 0; i < 4; i++) begin
      ddr2_ctrl_model_i.push({(i == 2), 8'h30 + 8'(i)}, i == 3);
    end
    ddr2_ctrl_model_i.issue(1'b0, ddr2_cmd_pkg::CMD_WR, 2'h1, 13'h004, 1'b1);
    n = 0;
    repeat (12) begin
      if (we === 1'b1) begin
        chk("wcol", wcol, 13'h4 + 13'(n));
        chk("wben", ben, 13'(n != 2));
        chk("wdat", wdat, 13'h30 + 13'(n));
        n++;
      end
      @(negedge clk);
    end
    chk("beats", 13'(n), 13'h4);
    ddr2_ctrl_model_i.issue(1'b0, ddr2_cmd_pkg::CMD_RD, 2'h1, 13'h400, 1'b1);
    repeat (8) @(negedge clk);
    chk("autopre", bo, 13'h0);
    ddr2_ctrl_model_i.issue(1'b0, ddr2_cmd_pkg::CMD_ACT, 2'h3, 13'h5, 1'b1);
    ddr2_ctrl_model_i.issue(1'b0, ddr2_cmd_pkg::CMD_PRE, 2'h0, 13'h400, 1'b1);
    chk("preall", bo, 13'h0);
    // Banks must finish precharging before the next activate or refresh.
    repeat (4) @(negedge clk);
    ddr2_ctrl_model_i.issue(1'b0, ddr2_cmd_pkg::CMD_ACT, 2'h2, 13'h9, 1'b1);
    chk("open2", bo, 13'h4);
    ddr2_ctrl_model_i.issue(1'b0, ddr2_cmd_pkg::CMD_PRE, 2'h2, 13'h0, 1'b1);
    chk("pre1", bo, 13'h0);
    repeat (4) @(negedge clk);
    for (int i = 0; i < 2; i++) begin
      ddr2_ctrl_model_i.issue(1'b0, ddr2_cmd_pkg::CMD_REF, 2'h0, 13'h1fff, 1'b1);
      chk("refrow", fr, 13'(i));
      repeat (4) @(negedge clk);
    end
    ddr2_ctrl_model_i.issue(1'b0, ddr2_cmd_pkg::CMD_REF, 2'h0, 13'h0, 1'b0);
    chk("sr", sr, 13'h1);
    chk("dlloff", dll, 13'h0);
    chk("srterm", tm, 13'h0);
    repeat (4) @(negedge clk);
    ddr2_ctrl_model_i.issue(1'b0, ddr2_cmd_pkg::CMD_NOP, 2'h0, 13'h0, 1'b1);
    chk("dllon", dll, 13'h1);
    print_verdict();
  end
endmodule
